// ===== led_mapper.sv
`timescale 1ns/1ps
`default_nettype none

// Combines mapped status bits into one LED drive level.
module led_mapper
	import tcs_pkg::*;
(
	input  wire logic     [7:0] status_on_i,
	input  wire led_map_t       map_i,
	output logic                led_o
);

	logic [7:0] lvl;   // Raw trace levels recovered from on/off.

	// An active-low input reads on when its trace is low, so the trace level is the inverse.
	// A low-true mapping lights when any selected trace is low; high-true when any is high.
	always_comb
	begin
		lvl = ~status_on_i;
		if (map_i.high_true)
		begin
			led_o = |(lvl & map_i.sel);                  // [RULE7]
		end
		else
		begin
			led_o = |(status_on_i & map_i.sel);          // [RULE6]
		end
	end

endmodule : led_mapper

`default_nettype wire

// ===== status_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for one asynchronous input bit.
module status_sync
(
	input  wire logic ref_clk_i,
	input  wire logic reset_i,
	input  wire logic async_i,
	output logic      sync_o
);

	logic meta_q;   // First stage, read only by the second stage.
	logic meta_d;   // Next value of the first stage.
	logic sync_q;   // Second stage, safe to use.
	logic sync_d;   // Next value of the second stage.

	// Next values; reset parks both stages at the idle (high) trace level.
	always_comb
	begin
		meta_d = async_i;
		sync_d = meta_q;
	end

	// Registers only.
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign sync_o = sync_q;

endmodule : status_sync

`default_nettype wire

// ===== target_board.sv
`timescale 1ns/1ps
`default_nettype none

// Target board model: open-collector traces with pull-ups, seen by the status lines.
module target_board
(
	input  wire logic [7:0] cmd_i,
	input  wire logic [7:0] cmd_oe_i,
	input  wire logic [7:0] level_n_i,
	output logic      [7:0] trace_o,
	output logic      [7:0] status_n_o
);
	// An enabled pin pulls its trace to its level; a released one loses to the pull-up.
	assign trace_o = ~(cmd_oe_i & ~cmd_i);
	// Board traces are wired-AND, so a command also shows on the status lines.
	assign status_n_o = trace_o & level_n_i;
endmodule : target_board

`default_nettype wire

// ===== target_command_status_led_io.sv
// Contract
// RULE1 - Eight independent command outputs for target traces.
// RULE2 - Asserted command drives trace low.
// RULE3 - Unasserted command is high impedance.
// RULE4 - Status reads on when trace low.
// RULE5 - Software reads all status bits anytime.
// RULE6 - Eight inputs mapped onto four LEDs.
// RULE7 - Each LED mapping has selectable polarity.
// RULE8 - Command zero serves as target reset.
// RULE9 - LED zero defaults to heartbeat.
// RULE10 - Network LEDs show rx, tx, link, polarity.
// RULE11 - Status inputs pass two-flop synchroniser.
//
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defines.svh"

module target_command_status_led_io
	import tcs_pkg::*;
#(
	parameter int unsigned    NCMD        = 8,
	parameter int unsigned    NSTAT       = 8,
	parameter int unsigned    HB_HALF_CYC = `HB_HALF_CYC
)
(
	input  wire logic         ref_clk_i,
	input  wire logic         reset_i,
	// AXI4-Lite slave.
	input  wire logic [7:0]   s_axi_awaddr,
	input  wire logic         s_axi_awvalid,
	output logic              s_axi_awready,
	input  wire logic [31:0]  s_axi_wdata,
	input  wire logic [3:0]   s_axi_wstrb,
	input  wire logic         s_axi_wvalid,
	output logic              s_axi_wready,
	output logic [1:0]        s_axi_bresp,
	output logic              s_axi_bvalid,
	input  wire logic         s_axi_bready,
	input  wire logic [7:0]   s_axi_araddr,
	input  wire logic         s_axi_arvalid,
	output logic              s_axi_arready,
	output logic [31:0]       s_axi_rdata,
	output logic [1:0]        s_axi_rresp,
	output logic              s_axi_rvalid,
	input  wire logic         s_axi_rready,
	// Target pins.
	output logic [NCMD-1:0]   cmd_o,
	output logic [NCMD-1:0]   cmd_oe_o,
	input  wire logic [NSTAT-1:0] status_n_i,
	// Network interface activity inputs, same clock.
	input  wire net_led_t     net_act_i,
	// Front panel.
	output logic [3:0]        status_led_o,
	output net_led_t          net_led_o
);

	// Software state.
	logic [NCMD-1:0]  cmd_q, cmd_d;            // Asserted command bits.
	led_map_t [3:0]   map_q, map_d;            // Per-LED mapping.
	logic [7:0]       ledctl_q, ledctl_d;      // Bit 0: LED 0 shows heartbeat.
	// Bus state.
	wr_state_t        wst_q, wst_d;
	rd_state_t        rst_q, rst_d;
	logic             aw_got_q, aw_got_d;      // Write address held.
	logic             w_got_q, w_got_d;        // Write data held.
	logic [7:0]       awaddr_q, awaddr_d;
	logic [31:0]      wdata_q, wdata_d;
	logic [3:0]       wstrb_q, wstrb_d;
	logic [1:0]       bresp_q, bresp_d;
	logic [31:0]      rdata_q, rdata_d;
	logic [1:0]       rresp_q, rresp_d;
	// Heartbeat.
	logic [31:0]      hb_cnt_q, hb_cnt_d;
	logic             hb_q, hb_d;
	// Pin and LED registers.
	logic [NCMD-1:0]  cmd_pin_q, cmd_oe_q;
	logic [3:0]       led_q, led_d;
	net_led_t         net_q;
	// Synchronised status, converted to on/off.
	logic [NSTAT-1:0] stat_sync;
	logic [NSTAT-1:0] stat_on;
	logic [3:0]       led_map_out;

	// Each status input crosses in through two flops before any use.
	genvar gi;
	generate
		for (gi = 0; gi < NSTAT; gi++)
		begin : g_sync
			status_sync u_sync
			(
				.ref_clk_i (ref_clk_i),
				.reset_i   (reset_i),
				.async_i   (status_n_i[gi]),
				.sync_o    (stat_sync[gi])       // [RULE11]
			);
		end
		for (gi = 0; gi < 4; gi++)
		begin : g_led
			led_mapper u_map
			(
				.status_on_i (stat_on[7:0]),
				.map_i       (map_q[gi]),
				.led_o       (led_map_out[gi])
			);
		end
	endgenerate

	// Low trace means on.
	assign stat_on = ~stat_sync;                        // [RULE4]

	// Heartbeat toggles every half period while the clock runs.
	always_comb
	begin
		if (hb_cnt_q >= HB_HALF_CYC - 1)
		begin
			hb_cnt_d = 32'h0000_0000;
			hb_d     = ~hb_q;
		end
		else
		begin
			hb_cnt_d = hb_cnt_q + 32'h0000_0001;
			hb_d     = hb_q;
		end
	end

	// LED drive: LED 0 takes the heartbeat unless software hands it to a mapping.
	always_comb
	begin
		led_d    = led_map_out;                         // [RULE6]
		if (ledctl_q[0])
		begin
			led_d[0] = hb_q;                            // [RULE9]
		end
	end

	// Write channel: address and data may arrive in either order; answer once both are held.
	always_comb
	begin
		wst_d    = wst_q;
		aw_got_d = aw_got_q;
		w_got_d  = w_got_q;
		awaddr_d = awaddr_q;
		wdata_d  = wdata_q;
		wstrb_d  = wstrb_q;
		bresp_d  = bresp_q;
		cmd_d    = cmd_q;
		map_d    = map_q;
		ledctl_d = ledctl_q;
		case (wst_q)
			WR_IDLE:
			begin
				if (s_axi_awvalid && !aw_got_q)
				begin
					aw_got_d = 1'b1;
					awaddr_d = s_axi_awaddr;
				end
				if (s_axi_wvalid && !w_got_q)
				begin
					w_got_d = 1'b1;
					wdata_d = s_axi_wdata;
					wstrb_d = s_axi_wstrb;
				end
				if (aw_got_q && w_got_q)
				begin
					// Only byte lane 0 and 1 carry data; other lanes are ignored.
					bresp_d = `RESP_OKAY;
					case (awaddr_q)
						`REG_CMD_OFS:
						begin
							if (wstrb_q[0])
							begin
								cmd_d = wdata_q[NCMD-1:0];      // [RULE1] [RULE8]
							end
						end
						`REG_MAP0_OFS, `REG_MAP1_OFS, `REG_MAP2_OFS, `REG_MAP3_OFS:
						begin
							if (wstrb_q[0])
							begin
								map_d[awaddr_q[3:2] - 2'd2].sel = wdata_q[7:0];
							end
							if (wstrb_q[1])
							begin
								map_d[awaddr_q[3:2] - 2'd2].high_true =
									wdata_q[`MAP_HIGH_BIT];       // [RULE7]
							end
						end
						`REG_LEDCTL_OFS:
						begin
							if (wstrb_q[0])
							begin
								ledctl_d = wdata_q[7:0];
							end
						end
						`REG_STATUS_OFS, `REG_NETLED_OFS:
						begin
							bresp_d = `RESP_OKAY;           // Read-only; write ignored.
						end
						default:
						begin
							bresp_d = `RESP_SLVERR;         // Unmapped address.
						end
					endcase
					aw_got_d = 1'b0;
					w_got_d  = 1'b0;
					wst_d    = WR_RESP;
				end
			end
			WR_RESP:
			begin
				if (s_axi_bready)
				begin
					wst_d = WR_IDLE;
				end
			end
			default:
			begin
				wst_d = WR_IDLE;
			end
		endcase
	end

	// Read channel: sample the register at the edge where the address is taken; the answer is valid the next cycle.
	always_comb
	begin
		rst_d   = rst_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rst_q)
			RD_IDLE:
			begin
				if (s_axi_arvalid)
				begin
					rresp_d = `RESP_OKAY;
					rdata_d = 32'h0000_0000;
					case (s_axi_araddr)
						`REG_CMD_OFS:    rdata_d[NCMD-1:0] = cmd_q;
						`REG_STATUS_OFS: rdata_d[NSTAT-1:0] = stat_on;   // [RULE5]
						`REG_MAP0_OFS:   rdata_d[8:0] = map_q[0];
						`REG_MAP1_OFS:   rdata_d[8:0] = map_q[1];
						`REG_MAP2_OFS:   rdata_d[8:0] = map_q[2];
						`REG_MAP3_OFS:   rdata_d[8:0] = map_q[3];
						`REG_LEDCTL_OFS: rdata_d[7:0] = ledctl_q;
						`REG_NETLED_OFS: rdata_d[3:0] = net_q;
						default:         rresp_d = `RESP_SLVERR;
					endcase
					rst_d = RD_RESP;
				end
			end
			RD_RESP:
			begin
				if (s_axi_rready)
				begin
					rst_d = RD_IDLE;
				end
			end
			default:
			begin
				rst_d = RD_IDLE;
			end
		endcase
	end

	// All registers of the block.
	always_ff @(posedge ref_clk_i)
	begin
		if (reset_i)
		begin
			cmd_q     <= `CMD_RST;
			map_q     <= {4{`MAP0_RST}} ;
			ledctl_q  <= `LEDCTL_RST;
			wst_q     <= WR_IDLE;
			rst_q     <= RD_IDLE;
			aw_got_q  <= 1'b0;
			w_got_q   <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h0000_0000;
			wstrb_q   <= 4'h0;
			bresp_q   <= `RESP_OKAY;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `RESP_OKAY;
			hb_cnt_q  <= 32'h0000_0000;
			hb_q      <= 1'b0;
			cmd_pin_q <= '0;
			cmd_oe_q  <= '0;
			led_q     <= 4'h0;
			net_q     <= '0;
		end
		else
		begin
			cmd_q     <= cmd_d;
			map_q     <= map_d;
			ledctl_q  <= ledctl_d;
			wst_q     <= wst_d;
			rst_q     <= rst_d;
			aw_got_q  <= aw_got_d;
			w_got_q   <= w_got_d;
			awaddr_q  <= awaddr_d;
			wdata_q   <= wdata_d;
			wstrb_q   <= wstrb_d;
			bresp_q   <= bresp_d;
			rdata_q   <= rdata_d;
			rresp_q   <= rresp_d;
			hb_cnt_q  <= hb_cnt_d;
			hb_q      <= hb_d;
			cmd_pin_q <= '0;                           // [RULE2]
			cmd_oe_q  <= cmd_d;                        // [RULE3]
			led_q     <= led_d;
			net_q     <= net_act_i;                    // [RULE10]
		end
	end

	// Ready signals are registered states: address and data taken while not yet held.
	assign s_axi_awready = (wst_q == WR_IDLE) && !aw_got_q;
	assign s_axi_wready  = (wst_q == WR_IDLE) && !w_got_q;
	assign s_axi_bvalid  = (wst_q == WR_RESP);
	assign s_axi_bresp   = bresp_q;
	assign s_axi_arready = (rst_q == RD_IDLE);
	assign s_axi_rvalid  = (rst_q == RD_RESP);
	assign s_axi_rdata   = rdata_q;
	assign s_axi_rresp   = rresp_q;
	assign cmd_o         = cmd_pin_q;
	assign cmd_oe_o      = cmd_oe_q;
	assign status_led_o  = led_q;
	assign net_led_o     = net_q;

endmodule : target_command_status_led_io

`default_nettype wire

// ===== target_command_status_led_io_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "tcs_defines.svh"

module target_command_status_led_io_tb;
	import tcs_pkg::*;
	localparam int unsigned HB = 4; // Short heartbeat keeps the run brief.
	logic        ref_clk_i     = 1'h0;
	logic        reset_i       = 1'h1;
	logic [7:0]  s_axi_awaddr  = 8'h00;
	logic        s_axi_awvalid = 1'h0;
	logic        s_axi_awready;
	logic [31:0] s_axi_wdata   = 32'h0;
	logic [3:0]  s_axi_wstrb   = 4'hF;
	logic        s_axi_wvalid  = 1'h0;
	logic        s_axi_wready;
	logic [1:0]  s_axi_bresp;
	logic        s_axi_bvalid;
	logic        s_axi_bready  = 1'h1; // Always ready for answers.
	logic [7:0]  s_axi_araddr  = 8'h00;
	logic        s_axi_arvalid = 1'h0;
	logic        s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0]  s_axi_rresp;
	logic        s_axi_rvalid;
	logic        s_axi_rready  = 1'h1;
	logic [7:0]  cmd_o;
	logic [7:0]  cmd_oe_o;
	logic [7:0]  status_n_i;
	net_led_t    net_act_i     = '0;
	logic [3:0]  status_led_o;
	net_led_t    net_led_o;
	logic [7:0]  level_n       = 8'hFF; // Levels the board puts on the status traces.
	logic [7:0]  trace;
	logic [31:0] rd_data;
	logic [1:0]  rd_resp;
	logic [1:0]  wr_resp; // Response code taken with the write answer.
	logic        prev;
	int          flips;
	int          mismatches      = 0;
	int          samples_checked = 0;
	logic [31:0] maps [4] = '{32'h0, 32'h3, 32'h105, 32'h102};

	target_command_status_led_io #(.HB_HALF_CYC(HB)) dut (.ref_clk_i, .reset_i,
		.s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .cmd_o, .cmd_oe_o, .status_n_i, .net_act_i,
		.status_led_o, .net_led_o);
	target_board board (.cmd_i(cmd_o), .cmd_oe_i(cmd_oe_o), .level_n_i(level_n),
		.trace_o(trace), .status_n_o(status_n_i));

	// Clock at 200 MHz.
	always #2.5 ref_clk_i = ~ref_clk_i;

	// Counts one comparison and reports a mismatch.
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Write: both channels offered together, each dropped once taken.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid  <= 1'h1;
		do
		begin
			@(posedge ref_clk_i);
			if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
			if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		wr_resp = s_axi_bresp;
	endtask : axi_wr

	// Read: the answer is taken at the edge where rvalid is seen.
	task automatic axi_rd(input logic [7:0] a);
		@(posedge ref_clk_i);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'h1;
		do
		begin
			@(posedge ref_clk_i);
			if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
		end while (s_axi_rvalid !== 1'h1);
		rd_data = s_axi_rdata;
		rd_resp = s_axi_rresp;
	endtask : axi_rd

	// Prints the counts and the verdict, then stops.
	task automatic complete_run;
		$display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : complete_run

	// Watchdog well beyond the hundred or so cycles the tests need.
	initial
	begin
		#50000;
		mismatches++;
		complete_run();
	end

	// Main sequence.
	initial
	begin
		repeat (16) @(posedge ref_clk_i);
		reset_i <= 1'h0;
		axi_rd(`REG_CMD_OFS);
		check("cmd reset", rd_data, 32'h0);
		axi_rd(`REG_LEDCTL_OFS);
		check("ledctl reset", rd_data, 32'h1);
		check("pins released", cmd_oe_o, 8'h00);
		// The heartbeat flips every HB cycles.
		flips = 0;
		prev = status_led_o[0];
		repeat (4 * HB)
		begin
			@(posedge ref_clk_i);
			if (status_led_o[0] !== prev) flips++;
			prev = status_led_o[0];
		end
		check("heartbeat flips", flips, 4);
		// Target reset and the top command pin, seen on the board and read back.
		axi_wr(`REG_CMD_OFS, 32'h81);
		repeat (5) @(posedge ref_clk_i);
		check("cmd enables", cmd_oe_o, 8'h81);
		check("board traces", trace, 8'h7E);
		axi_rd(`REG_STATUS_OFS);
		check("status on", rd_data, 32'h81);
		// Mapping with both polarities; LED 0 taken from the heartbeat.
		axi_wr(`REG_CMD_OFS, 32'h02);
		axi_wr(`REG_LEDCTL_OFS, 32'h0);
		for (int i = 0; i < 4; i++) axi_wr(`REG_MAP0_OFS + 8'(i * 4), maps[i]);
		repeat (5) @(posedge ref_clk_i);
		check("leds mapped", status_led_o, 4'h6);
		axi_rd(`REG_MAP2_OFS);
		check("map readback", rd_data, 32'h105);
		axi_wr(`REG_MAP0_OFS, 32'h110);
		repeat (2) @(posedge ref_clk_i);
		check("led0 high true", status_led_o, 4'h7);
		// Network LEDs follow the interface and read back.
		net_act_i <= net_led_t'(4'hA);
		repeat (2) @(posedge ref_clk_i);
		check("net leds", net_led_o, 4'hA);
		axi_rd(`REG_NETLED_OFS);
		check("net readback", rd_data, 32'hA);
		// Lane 0 alone updates the select mask and leaves the polarity bit alone.
		s_axi_wstrb <= 4'h1;
		axi_wr(`REG_MAP1_OFS, 32'h1F0);
		check("lane write resp", wr_resp, `RESP_OKAY);
		s_axi_wstrb <= 4'hF;
		axi_rd(`REG_MAP1_OFS);
		check("lane 1 kept", rd_data, 32'hF0);
		// A write to an unmapped place is refused.
		axi_wr(8'h20, 32'hFF);
		check("unmapped write", wr_resp, `RESP_SLVERR);
		// An unmapped place is refused.
		axi_rd(8'h20);
		check("unmapped resp", rd_resp, `RESP_SLVERR);
		check("unmapped data", rd_data, 32'h0);
		complete_run();
	end
endmodule : target_command_status_led_io_tb

`default_nettype wire

// ===== tcs_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none

// Watches bus handshakes, pin timing and the network LED copy.
module tcs_chk
	import tcs_pkg::*;
(
	input wire logic        ref_clk_i,
	input wire logic        reset_i,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic [7:0]  cmd_o,
	input wire logic [7:0]  cmd_oe_o,
	input wire net_led_t    net_act_i,
	input wire net_led_t    net_led_o
);
	// All checks share the one clock domain.
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (reset_i);

	chk_cmd_level: assert property (cmd_o == 8'h00)
		else $error("command pin level is not low");
	chk_oe_commit: assert property ($changed(cmd_oe_o) |-> s_axi_bvalid && !$past(s_axi_bvalid))
		else $error("command enables moved outside a write commit");
	chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> !s_axi_bvalid ##1 s_axi_bvalid)
		else $error("write answer not two edges after the request");
	chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read address taken while answering");
	chk_b_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answering");
	chk_net_copy: assert property (!$past(reset_i) |-> net_led_o == $past(net_act_i))
		else $error("network LEDs are not a one cycle copy");
	chk_reset_quiet: assert property ($past(reset_i) |-> cmd_oe_o == 8'h00 && !s_axi_rvalid)
		else $error("pins or answers active straight after reset");
endmodule : tcs_chk

bind target_command_status_led_io tcs_chk u_chk (.ref_clk_i, .reset_i, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rvalid, .cmd_o, .cmd_oe_o, .net_act_i, .net_led_o);

`default_nettype wire

// ===== tcs_defines.svh
`ifndef TCS_DEFINES_SVH
`define TCS_DEFINES_SVH

// Register byte offsets on the AXI4-Lite bus.
`define REG_CMD_OFS      8'h00
`define REG_STATUS_OFS   8'h04
`define REG_MAP0_OFS     8'h08
`define REG_MAP1_OFS     8'h0C
`define REG_MAP2_OFS     8'h10
`define REG_MAP3_OFS     8'h14
`define REG_LEDCTL_OFS   8'h18
`define REG_NETLED_OFS   8'h1C

// Reset values.
`define CMD_RST          8'h00
`define MAP0_RST         9'h000
`define LEDCTL_RST       8'h01

// Field positions inside a map register: select mask in [7:0], high-true in bit 8.
`define MAP_SEL_LSB      0
`define MAP_HIGH_BIT     8

// Heartbeat half period in ns and the derived cycle count at 200 MHz.
`define HB_HALF_NS       250000000
`define CLK_PERIOD_NS    5
`define HB_HALF_CYC      (`HB_HALF_NS / `CLK_PERIOD_NS)

// AXI response codes.
`define RESP_OKAY        2'b00
`define RESP_SLVERR      2'b10

`endif

// ===== tcs_pkg.sv
package tcs_pkg;

	// One status LED mapping: which inputs feed it and its polarity.
	typedef struct packed {
		logic       high_true;
		logic [7:0] sel;
	} led_map_t;

	// Network activity LED group.
	typedef struct packed {
		logic rx;
		logic tx;
		logic link;
		logic polarity;
	} net_led_t;

	// Read channel answer states, Gray ordered.
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_RESP = 2'b01
	} rd_state_t;

	// Write channel answer states, Gray ordered.
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} wr_state_t;

endpackage : tcs_pkg
